// File: design/low_duty_cycle_wake_sequencer.sv
`timescale 1ns/1ps
module low_duty_cycle_wake_sequencer
    import wake_seq_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               tick_32k,
    input  wire wake_cfg_t          wake_timer_config,
    input  wire logic [MANT_W-1:0]  wake_mantissa,
    input  wire logic [EXP_W-1:0]   wake_exponent,
    input  wire logic [WIN_W-1:0]   listen_window_setting,
    input  wire logic [THR_W-1:0]   battery_threshold_setting,
    input  wire logic [MV_W-1:0]    battery_mv,
    input  wire logic               interrupt_enable_setting,
    input  wire chip_irq_en_t       chip_interrupt_enable_setting,
    input  wire radio_evt_t         radio_events,
    input  wire logic [FLAG_W-1:0]  flag_clear,
    output seq_state_t              seq_state_ff,
    output logic                    rx_enable_ff,
    output logic                    tx_start_ff,
    output logic [FLAG_W-1:0]       irq_flags_ff,
    output logic                    interrupt_request_n_ff,
    output logic                    low_battery_ff,
    output logic                    low_battery_gpio_ff
);

    seq_state_t              nxt_state;
    logic                    heard_ff;
    logic                    nxt_heard;
    logic [FLAG_W-1:0]       nxt_flags;

    wire  [TICK_W-1:0]       wake_ticks;
    wire  [TICK_W-1:0]       window_ticks;
    wire                     wake_expire;
    wire                     window_expire;
    wire                     in_rx;
    wire                     in_wait;
    wire                     start_window;
    wire                     lbd_active;
    wire                     lbd_sample;
    wire                     batt_below;
    wire                     batt_done;
    wire                     tx_finish;
    wire                     pkt_heard;
    wire  [FLAG_W-1:0]       flag_set;

    // both periods in ticks of the 32.768 kHz base, scaled by 4 * 2^exp
    assign wake_ticks   = TICK_W'(wake_mantissa)
                          << (32'(wake_exponent) + PERIOD_SCALE_LOG2);
    assign window_ticks = TICK_W'(listen_window_setting)
                          << (32'(wake_exponent) + PERIOD_SCALE_LOG2);

    assign in_wait      = seq_state_ff == ST_WAKE_WAIT;
    assign in_rx        = (seq_state_ff == ST_RX_LISTEN) || (seq_state_ff == ST_RX_EXTEND);
    assign pkt_heard    = radio_events.preamble_valid | radio_events.sync_ok;
    assign tx_finish    = (seq_state_ff == ST_TX_SEND) & radio_events.tx_done;
    assign lbd_active   = wake_timer_config.wake_enable & wake_timer_config.lbd_enable;
    assign lbd_sample   = wake_expire & lbd_active;
    // restart the window on each entry so the second window is full length
    assign start_window = (nxt_state == ST_RX_LISTEN && !(seq_state_ff == ST_RX_LISTEN))
                          || (nxt_state == ST_RX_EXTEND && seq_state_ff == ST_RX_LISTEN);

    period_counter u_wake_timer (
        .clk       (clk),
        .srst      (srst),
        .restart   (!wake_timer_config.wake_enable),
        .run       (wake_timer_config.wake_enable),
        .tick      (tick_32k),
        .target    (wake_ticks),
        .expire_ff (wake_expire)
    );

    period_counter u_window_timer (
        .clk       (clk),
        .srst      (srst),
        .restart   (start_window),
        .run       (in_rx),
        .tick      (tick_32k),
        .target    (window_ticks),
        .expire_ff (window_expire)
    );

    battery_compare u_battery (
        .clk               (clk),
        .srst              (srst),
        .sample            (lbd_sample),
        .threshold_setting (battery_threshold_setting),
        .battery_mv        (battery_mv),
        .below_ff          (batt_below),
        .done_ff           (batt_done)
    );

    always_comb begin
        nxt_state = seq_state_ff;
        nxt_heard = heard_ff;
        case (seq_state_ff)
            ST_WAKE_WAIT: begin
                nxt_heard = 1'b0;
                if (wake_expire && wake_timer_config.rx_ldc_enable) begin
                    nxt_state = ST_RX_LISTEN;
                end else if (wake_expire && wake_timer_config.tx_ldc_enable) begin
                    nxt_state = ST_TX_SEND;
                end
            end
            ST_RX_LISTEN: begin
                // wake expiries are ignored while listening, relying on a short window
                if (radio_events.packet_valid) begin
                    nxt_state = ST_WAKE_WAIT;
                end else if (window_expire && (heard_ff || pkt_heard)
                             && !radio_events.rx_error) begin
                    nxt_state = ST_RX_EXTEND;
                end else if (window_expire) begin
                    nxt_state = ST_WAKE_WAIT;
                end
                if (radio_events.rx_error) begin
                    nxt_heard = 1'b0;
                end else if (pkt_heard) begin
                    nxt_heard = 1'b1;
                end
            end
            ST_RX_EXTEND: begin
                if (radio_events.packet_valid || window_expire) begin
                    nxt_state = ST_WAKE_WAIT;
                end
            end
            ST_TX_SEND: begin
                if (radio_events.tx_done) begin
                    nxt_state = ST_WAKE_WAIT;
                end
            end
            default: begin
                nxt_state = ST_WAKE_WAIT;
                nxt_heard = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            seq_state_ff <= ST_WAKE_WAIT;
            heard_ff     <= 1'b0;
            rx_enable_ff <= 1'b0;
            tx_start_ff  <= 1'b0;
        end else begin
            seq_state_ff <= nxt_state;
            heard_ff     <= nxt_heard;
            rx_enable_ff <= (nxt_state == ST_RX_LISTEN) || (nxt_state == ST_RX_EXTEND);
            tx_start_ff  <= (nxt_state == ST_TX_SEND) && in_wait;
        end
    end

    assign flag_set[FLAG_WAKE] = wake_expire & chip_interrupt_enable_setting.wake_en;
    assign flag_set[FLAG_BATT] = batt_done & batt_below & !wake_timer_config.lbd_to_gpio
                                 & chip_interrupt_enable_setting.batt_en;
    assign flag_set[FLAG_TX]   = tx_finish & interrupt_enable_setting;

    // a set in the same cycle as its clear wins, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
            assign nxt_flags[gi] = flag_set[gi] | (irq_flags_ff[gi] & ~flag_clear[gi]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_flags_ff           <= FLAGS_RST;
            interrupt_request_n_ff <= 1'b1;
        end else begin
            irq_flags_ff           <= nxt_flags;
            interrupt_request_n_ff <= ~(|irq_flags_ff);
        end
    end

    // gpio path copies the last comparison while lbd_to_gpio is set; it moves on a new result or a change of lbd_to_gpio
    always_ff @(posedge clk) begin
        if (srst) begin
            low_battery_ff      <= 1'b0;
            low_battery_gpio_ff <= 1'b0;
        end else begin
            if (batt_done) begin
                low_battery_ff <= batt_below;
            end
            low_battery_gpio_ff <= low_battery_ff & wake_timer_config.lbd_to_gpio;
        end
    end

    sequence irq_after_flag_s(int idx);
        irq_flags_ff[idx] ##1 !interrupt_request_n_ff;
    endsequence

    sequence window_return_s;
        (seq_state_ff == ST_WAKE_WAIT) && !rx_enable_ff;
    endsequence

    property tx_irq_p;
        @(posedge clk) disable iff (srst)
        (tx_finish && interrupt_enable_setting) |=> irq_after_flag_s(FLAG_TX);
    endproperty
    tx_irq_a: assert property (tx_irq_p)
        else $error("tx done did not pull interrupt low");

    property wake_irq_p;
        @(posedge clk) disable iff (srst)
        (wake_expire && chip_interrupt_enable_setting.wake_en) |=> irq_after_flag_s(FLAG_WAKE);
    endproperty
    wake_irq_a: assert property (wake_irq_p)
        else $error("wake expiry did not pull interrupt low");

    tx_return_a: assert property (
        @(posedge clk) disable iff (srst)
        tx_finish |=> (seq_state_ff == ST_WAKE_WAIT) && !tx_start_ff)
        else $error("no return to wait after transmit");

    tx_wake_a: assert property (
        @(posedge clk) disable iff (srst)
        (in_wait && wake_expire && !wake_timer_config.rx_ldc_enable
         && wake_timer_config.tx_ldc_enable)
        |=> (seq_state_ff == ST_TX_SEND) && tx_start_ff ##1 !tx_start_ff)
        else $error("tx wake did not start one send");

    rx_wake_a: assert property (
        @(posedge clk) disable iff (srst)
        (in_wait && wake_expire && wake_timer_config.rx_ldc_enable)
        |=> (seq_state_ff == ST_RX_LISTEN) && rx_enable_ff)
        else $error("rx wake did not open a window");

    no_ldc_a: assert property (
        @(posedge clk) disable iff (srst)
        (in_wait && !wake_timer_config.rx_ldc_enable && !wake_timer_config.tx_ldc_enable)
        |=> in_wait)
        else $error("left wait with duty cycling off");

    window_end_a: assert property (
        @(posedge clk) disable iff (srst)
        (seq_state_ff == ST_RX_LISTEN && window_expire && !heard_ff && !pkt_heard)
        |=> window_return_s)
        else $error("quiet window did not end");

    window_extend_a: assert property (
        @(posedge clk) disable iff (srst)
        (seq_state_ff == ST_RX_LISTEN && window_expire && heard_ff
         && !radio_events.packet_valid && !radio_events.rx_error)
        |=> (seq_state_ff == ST_RX_EXTEND) && rx_enable_ff)
        else $error("heard preamble did not extend window");

    second_end_a: assert property (
        @(posedge clk) disable iff (srst)
        (seq_state_ff == ST_RX_EXTEND && window_expire) |=> window_return_s)
        else $error("second window did not end");

    lbd_off_a: assert property (
        @(posedge clk) disable iff (srst)
        !lbd_active |=> !batt_done)
        else $error("battery check ran while disabled");

    lbd_result_a: assert property (
        @(posedge clk) disable iff (srst)
        lbd_sample |=> ##1 (low_battery_ff == $past(batt_below)))
        else $error("battery result not latched");

    // gpio routing shows the low result one cycle after it is latched
    sequence batt_low_s;
        batt_done && batt_below ##1 wake_timer_config.lbd_to_gpio;
    endsequence

    batt_irq_a: assert property (
        @(posedge clk) disable iff (srst)
        (batt_done && batt_below && !wake_timer_config.lbd_to_gpio
         && chip_interrupt_enable_setting.batt_en) |=> irq_after_flag_s(FLAG_BATT))
        else $error("low battery did not pull interrupt low");

    batt_gpio_a: assert property (
        @(posedge clk) disable iff (srst)
        (batt_done && wake_timer_config.lbd_to_gpio && !irq_flags_ff[FLAG_BATT])
        |=> !irq_flags_ff[FLAG_BATT])
        else $error("gpio routed battery result raised a flag");

    gpio_follow_a: assert property (
        @(posedge clk) disable iff (srst)
        batt_low_s |=> low_battery_gpio_ff)
        else $error("low battery missing on gpio");

    tx_quiet_a: assert property (
        @(posedge clk) disable iff (srst)
        (tx_finish && !interrupt_enable_setting && !irq_flags_ff[FLAG_TX])
        |=> !irq_flags_ff[FLAG_TX])
        else $error("tx flag set while disabled");

    wake_quiet_a: assert property (
        @(posedge clk) disable iff (srst)
        (wake_expire && !chip_interrupt_enable_setting.wake_en && !irq_flags_ff[FLAG_WAKE])
        |=> !irq_flags_ff[FLAG_WAKE])
        else $error("wake flag set while disabled");

    third_window_a: assert property (
        @(posedge clk) disable iff (srst)
        (seq_state_ff == ST_RX_EXTEND) |=> (seq_state_ff != ST_RX_LISTEN))
        else $error("extended window reopened listening");

    tx_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        (seq_state_ff == ST_TX_SEND && !radio_events.tx_done)
        |=> (seq_state_ff == ST_TX_SEND) && !rx_enable_ff)
        else $error("send left before tx done");

endmodule // low_duty_cycle_wake_sequencer

// File: design/wake_seq_pkg.sv
package wake_seq_pkg;

    // timing base of the wake timer, in Hz (32.768 kHz)
    localparam int TIMER_BASE_HZ     = 32768;
    // the factor of four in front of the power of two
    localparam int PERIOD_SCALE      = 4;
    localparam int PERIOD_SCALE_LOG2 = 2;

    localparam int MANT_W = 16;
    localparam int EXP_W  = 4;
    localparam int WIN_W  = 8;
    localparam int THR_W  = 5;
    localparam int MV_W   = 12;
    // wide enough for a 16-bit mantissa shifted by 15 + 2
    localparam int TICK_W = 34;

    // battery threshold ladder in mV: 1500 + 50 * setting, up to 3050
    localparam logic [MV_W-1:0] BATT_MIN_MV  = 12'h5dc;
    localparam logic [MV_W-1:0] BATT_STEP_MV = 12'h032;
    localparam logic [MV_W-1:0] BATT_MAX_MV  = 12'hbea;

    localparam int FLAG_W    = 3;
    localparam int FLAG_WAKE = 0;
    localparam int FLAG_BATT = 1;
    localparam int FLAG_TX   = 2;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;

    typedef enum logic [1:0] {
        ST_WAKE_WAIT = 2'b00,
        ST_RX_LISTEN = 2'b01,
        ST_RX_EXTEND = 2'b11,
        ST_TX_SEND   = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic wake_enable;
        logic rx_ldc_enable;
        logic tx_ldc_enable;
        logic lbd_enable;
        logic lbd_to_gpio;
    } wake_cfg_t;

    typedef struct packed {
        logic wake_en;
        logic batt_en;
    } chip_irq_en_t;

    typedef struct packed {
        logic preamble_valid;
        logic sync_ok;
        logic packet_valid;
        logic rx_error;
        logic tx_done;
    } radio_evt_t;

endpackage

// File: design/period_counter.sv
`timescale 1ns/1ps
module period_counter
    import wake_seq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              restart,
    input  wire logic              run,
    input  wire logic              tick,
    input  wire logic [TICK_W-1:0] target,
    output logic                   expire_ff
);

    logic [TICK_W-1:0] count_ff;
    wire  [TICK_W-1:0] count_inc;
    wire               hit;

    assign count_inc = count_ff + 1'b1;
    // a zero target behaves as one tick, never as a stuck counter
    assign hit       = run & tick & (count_inc >= target);

    always_ff @(posedge clk) begin
        if (srst || restart) begin
            count_ff  <= '0;
            expire_ff <= 1'b0;
        end else begin
            expire_ff <= hit;
            if (hit) begin
                count_ff <= '0;
            end else if (run && tick) begin
                count_ff <= count_inc;
            end
        end
    end

endmodule // period_counter

// File: design/battery_compare.sv
`timescale 1ns/1ps
module battery_compare
    import wake_seq_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire logic            sample,
    input  wire logic [THR_W-1:0] threshold_setting,
    input  wire logic [MV_W-1:0] battery_mv,
    output logic                 below_ff,
    output logic                 done_ff
);

    wire [MV_W-1:0] thr_mv;
    wire            below;

    // top step lands exactly on the 3.05 V ceiling
    assign thr_mv = BATT_MIN_MV + MV_W'(threshold_setting) * BATT_STEP_MV;
    assign below  = battery_mv < thr_mv;

    always_ff @(posedge clk) begin
        if (srst) begin
            below_ff <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= sample;
            if (sample) begin
                below_ff <= below;
            end
        end
    end

endmodule // battery_compare

// File: verif/host_model.sv
`timescale 1ns/1ps
module host_model
    import wake_seq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              slow,
    input  wire logic              irq_n,
    input  wire logic [FLAG_W-1:0] flags,
    output logic [FLAG_W-1:0]      clear_ff
);
    // firmware answers late; slow mode stretches the latency
    logic [3:0] wait_ff;
    wire  [3:0] delay = slow ? 4'hc : 4'h4;

    always_ff @(posedge clk) begin
        if (srst) begin
            clear_ff <= '0;
            wait_ff  <= '0;
        end else begin
            clear_ff <= '0;
            wait_ff  <= '0;
            if (!irq_n && clear_ff == '0) begin
                wait_ff <= wait_ff + 4'h1;
                // clears only what it read, so a late flag is not lost
                if (wait_ff == delay) begin
                    clear_ff <= flags;
                    wait_ff  <= '0;
                end
            end
        end
    end
endmodule // host_model

// File: verif/low_duty_cycle_wake_sequencer_test.sv
`timescale 1ns/1ps
module low_duty_cycle_wake_sequencer_test;
    import wake_seq_pkg::*;

    logic               clk  = 1'b0;
    logic               srst = 1'b1;
    logic               tick_32k = 1'b0;
    wake_cfg_t          cfg  = '0;
    logic [MANT_W-1:0]  mant = '0;
    logic [EXP_W-1:0]   expo = '0;
    logic [WIN_W-1:0]   win  = '0;
    logic [THR_W-1:0]   thr  = '0;
    logic [MV_W-1:0]    mv   = '0;
    logic               ie   = 1'b0;
    chip_irq_en_t       chip = '0;
    radio_evt_t         evt  = '0;
    logic               slow = 1'b0;
    seq_state_t         state;
    logic               rx_en;
    logic               tx_start;
    logic [FLAG_W-1:0]  flags;
    logic [FLAG_W-1:0]  clr;
    logic               irq_n;
    logic               low_batt;
    logic               gpio;
    int                 n_errors = 0;
    int                 n_checks = 0;
    int                 seed = 90362;
    int                 tick_total = 0;
    int                 mark = 0;
    int                 div = 0;
    int                 p, w, n, m, e, wn, t, below, g;
    int                 exp_q[$];

    always #20 clk = ~clk;

    // ticks every third cycle: fast, so two can fall inside one host latency walk
    always @(posedge clk) begin
        div      <= (div == 2) ? 0 : div + 1;
        tick_32k <= (div == 2);
        if (tick_32k === 1'b1) tick_total <= tick_total + 1;
    end

    low_duty_cycle_wake_sequencer low_duty_cycle_wake_sequencer_inst (
        .clk(clk), .srst(srst), .tick_32k(tick_32k), .wake_timer_config(cfg),
        .wake_mantissa(mant), .wake_exponent(expo), .listen_window_setting(win),
        .battery_threshold_setting(thr), .battery_mv(mv), .interrupt_enable_setting(ie),
        .chip_interrupt_enable_setting(chip), .radio_events(evt), .flag_clear(clr),
        .seq_state_ff(state), .rx_enable_ff(rx_en), .tx_start_ff(tx_start),
        .irq_flags_ff(flags), .interrupt_request_n_ff(irq_n), .low_battery_ff(low_batt),
        .low_battery_gpio_ff(gpio)
    );

    host_model host_model_inst (
        .clk(clk), .srst(srst), .slow(slow), .irq_n(irq_n), .flags(flags), .clear_ff(clr)
    );

    function automatic int ticks_of(input int v, input int x);
        return v * 4 * (1 << x);
    endfunction

    function automatic int thr_mv(input int s);
        return 1500 + 50 * s;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, expv, seen);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ticks are counted from the previous mark, so pulses in between still count
    task automatic wait_state(input seq_state_t s, output int nt);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (state !== s && k < 3000);
        check("state reached", state, s);
        nt = tick_total - mark;
        mark = tick_total;
    endtask

    task automatic wait_ticks(input int k);
        while (tick_total - mark < k) @(negedge clk);
        mark = tick_total;
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge clk) evt <= radio_evt_t'(v);
        @(posedge clk) evt <= '0;
    endtask

    // one edge with the timer off restarts the period count
    task automatic set_cfg(input logic [4:0] c);
        @(posedge clk) cfg <= '0;
        @(posedge clk) cfg <= wake_cfg_t'(c);
        @(negedge clk) mark = tick_total;
    endtask

    task automatic wait_clear;
        int k;
        k = 0;
        while ((flags !== '0 || irq_n !== 1'b1) && k < 400) begin
            @(negedge clk);
            k++;
        end
        check("flags cleared", {flags, irq_n}, 4'h1);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        $display("watchdog expired");
        summarize;
    end

    initial begin
        m  = 3 + ($random(seed) & 1);
        e  = $random(seed) & 1;
        wn = 1 + ($random(seed) & 1);
        p  = ticks_of(m, e);
        w  = ticks_of(wn, e);
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        mant <= MANT_W'(m);
        expo <= EXP_W'(e);
        win  <= WIN_W'(wn);
        @(negedge clk);
        check("reset outputs", {state, rx_en, tx_start, flags, irq_n, low_batt, gpio},
              10'h004);
        $display("test reset done");

        @(posedge clk) chip <= chip_irq_en_t'(2'h1);
        set_cfg(5'h02);
        wait_ticks(2 * p);
        check("battery idle", {low_batt, flags}, 4'h0);
        $display("test battery without timer done");

        @(posedge clk) chip <= chip_irq_en_t'(2'h2);
        set_cfg(5'h18);
        wait_state(ST_RX_LISTEN, n);
        check("wake period", n, p);
        check("wake flag", flags[FLAG_WAKE], 1'b1);
        check("rx enable", rx_en, 1'b1);
        wait_state(ST_WAKE_WAIT, n);
        check("listen window", n, w);
        wait_state(ST_RX_LISTEN, n);
        check("next wake", n, p - w);
        pulse(5'h10);
        wait_state(ST_RX_EXTEND, n);
        check("preamble extend", n, w);
        wait_state(ST_WAKE_WAIT, n);
        check("second window", n, w);
        wait_state(ST_RX_LISTEN, n);
        pulse(5'h08);
        wait_state(ST_RX_EXTEND, n);
        check("sync extend", n, w);
        pulse(5'h04);
        @(negedge clk);
        check("packet ends rx", state, ST_WAKE_WAIT);
        wait_state(ST_RX_LISTEN, n);
        pulse(5'h10);
        pulse(5'h02);
        wait_state(ST_WAKE_WAIT, n);
        check("error no extend", n, w);
        wait_state(ST_RX_LISTEN, n);
        pulse(5'h04);
        @(negedge clk);
        check("packet ends listen", state, ST_WAKE_WAIT);
        $display("test rx duty cycle done");

        @(posedge clk) chip <= '0;
        wait_clear;
        set_cfg(5'h14);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) ie <= i[0];
            wait_state(ST_TX_SEND, n);
            check("tx period", n, p);
            check("tx start", tx_start, 1'b1);
            check("no wake flag", flags[FLAG_WAKE], 1'b0);
            @(negedge clk);
            check("tx start pulse", tx_start, 1'b0);
            pulse(5'h01);
            @(negedge clk);
            check("tx back to wait", state, ST_WAKE_WAIT);
            check("tx flag", flags[FLAG_TX], i[0]);
            @(negedge clk);
            check("tx irq", irq_n, !i[0]);
            wait_clear;
        end
        $display("test tx duty cycle done");

        @(posedge clk) slow <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            t     = (i == 0) ? 0 : (i == 1) ? 31 : ($random(seed) & 31);
            below = (i % 2 == 0);
            g     = i / 2;
            exp_q.push_back(below);
            @(posedge clk) begin
                thr  <= THR_W'(t);
                mv   <= MV_W'(thr_mv(t) - below);
                chip <= chip_irq_en_t'(2'h1);
            end
            set_cfg(5'h12 | 5'(g));
            wait_ticks(p);
            repeat (4) @(negedge clk);
            check("battery result", low_batt, exp_q.pop_front());
            check("battery gpio", gpio, below[0] & g[0]);
            check("battery flag", flags[FLAG_BATT], below[0] & !g[0]);
            check("battery irq", irq_n, !(below[0] & !g[0]));
            check("no duty cycle", state, ST_WAKE_WAIT);
            wait_clear;
        end
        $display("test low battery done");
        summarize;
    end
endmodule // low_duty_cycle_wake_sequencer_test
